//--- src/aas_pkg.sv
package aas_pkg;

	localparam logic [7:0]  OFS_CTRL     = 8'h00;
	localparam logic [7:0]  OFS_STAT     = 8'h04;
	localparam logic [7:0]  OFS_PRELOAD  = 8'h08;
	localparam logic [7:0]  OFS_RESULT   = 8'h0C;
	localparam logic [7:0]  OFS_COUNT    = 8'h10;

	localparam int          CTRL_CFG_W   = 10;
	localparam int          CTRL_START   = 10;
	localparam int          STAT_START   = 0;
	localparam int          STAT_RUN     = 1;
	localparam int          STAT_IRQ     = 2;
	localparam int          STAT_OVR     = 3;
	localparam int          STAT_BUSY    = 4;

	localparam logic [1:0]  TSEL_TIMER   = 2'h2;
	localparam logic [1:0]  TSEL_FREE    = 2'h3;

	localparam int          TMR_W        = 16;
	localparam logic [15:0] TMR_FULL     = 16'hFFFF;
	localparam logic [15:0] PRELOAD_RST  = 16'h0000;
	localparam int          DATA_W       = 12;
	localparam int          CNT_W        = 8;

	typedef struct packed
	{
		logic [3:0] gap;
		logic       two;
		logic [2:0] nsel;
		logic [1:0] tsel;
	} aas_cfg_s;

	localparam aas_cfg_s    CFG_RST      = '0;

	typedef struct packed
	{
		logic start;
		logic chan;
	} aas_conv_req_s;

	typedef struct packed
	{
		logic              done;
		logic [DATA_W-1:0] data;
	} aas_conv_rsp_s;

	typedef enum
	{
		S_IDLE,
		S_WAIT,
		S_CONV,
		S_GAP,
		S_DRAIN
	} aas_state_e;

endpackage : aas_pkg

//--- src/aas_sequencer.sv
`timescale 1ns/1ps

// Behaviour
// - Timer mode with nonzero count: auto_start arms overflow-triggered conversions.
// - Setting auto_start in timer mode also sets timer_run.
// - Counter counts up from timer_preload; overflow at FFFFH starts a conversion.
// - After overflow counter reloads and keeps counting; each overflow in S_WAIT triggers next.
// - Timer mode: after N conversions clear timer_run, auto_start, set adc_irq_flag.
// - N comes from the three-bit auto_count_sel field.
// - Software may clear auto_start any time to abandon the sequence.
// - Start attempts while auto_start is high are ignored.
// - Clear while busy: finish conversion, return to idle when conv_busy falls.
// - Timer mode clear while idle: stop counter at once, reset sequencer.
// - Clear after N conversions completed still raises the completion flag.
// - auto_start rising in timer mode clears overrun_flag, sets timer_run.
// - Overflow during a conversion sets overrun_flag and is ignored.
// - Two-channel timer: overflow gives ch1, gap, ch2, then waits for overflow.
// - Two-channel timer: overflow before pair done sets overrun_flag, ignored.
// - In two-channel operation N counts pairs, not conversions.
// - Result holds first value, then running sum, then final total.
// - Free mode: start converts at once, later ones after the interval gap.
// - Free mode: after N conversions clear auto_start and set adc_irq_flag.
// - Free mode clear while idle resets the sequencer at once.
// - Free single-channel start clears overrun_flag and converts at once.
// - Free two-channel: ch1, gap, ch2, gap, repeating for N pairs.
// - conv_busy is high during a conversion and low once it completes.
module aas_sequencer #(
	parameter int ACC_W    = 16,
	parameter int N_SCALE  = 1,
	parameter int GAP_UNIT = 4
) (
	input  wire logic                   ref_clk_i,
	input  wire logic                   resetn_i,
	input  wire logic [7:0]             reg_addr_i,
	input  wire logic [31:0]            reg_wdata_i,
	input  wire logic                   reg_wr_i,
	input  wire logic                   reg_rd_i,
	output logic      [31:0]            reg_rdata_o,
	output aas_pkg::aas_conv_req_s      conv_req_o,
	input  wire aas_pkg::aas_conv_rsp_s conv_rsp_i,
	output logic                        conv_busy_o,
	output logic                        adc_irq_flag_o
);
	import aas_pkg::*;

	if (N_SCALE < 1 || 7 * N_SCALE > 255)
		$error("N_SCALE out of range");
	if (GAP_UNIT < 1 || GAP_UNIT > 255)
		$error("GAP_UNIT out of range");
	if (ACC_W < DATA_W + 4 || ACC_W > 32)
		$error("ACC_W out of range");

	function automatic logic [CNT_W-1:0] n_of(input logic [2:0] sel);
		n_of = CNT_W'(int'(sel) * N_SCALE);
	endfunction : n_of

	aas_state_e       state;
	aas_state_e       next_state;
	aas_cfg_s         cfg;
	logic             auto_start;
	logic             timer_run;
	logic             overrun;
	logic [TMR_W-1:0] tcnt;
	logic [TMR_W-1:0] preload;
	logic [ACC_W-1:0] acc;
	logic [CNT_W-1:0] pair_cnt;
	logic [CNT_W-1:0] n_target;
	logic             chan;
	logic             gap_chan;
	logic [7:0]       unit_cnt;
	logic [3:0]       gap_cnt;
	logic             fire;
	logic             fire_chan;
	logic             gap_enter;
	logic             next_gap_chan;

	// Register decode
	wire       wr_ctrl   = reg_wr_i && (reg_addr_i == OFS_CTRL);
	wire       wr_stat   = reg_wr_i && (reg_addr_i == OFS_STAT);
	wire       wr_pre    = reg_wr_i && (reg_addr_i == OFS_PRELOAD);
	wire aas_cfg_s wcfg  = aas_cfg_s'(reg_wdata_i[CTRL_CFG_W-1:0]);
	wire       start_req = wr_ctrl && reg_wdata_i[CTRL_START];
	wire       stop_req  = wr_ctrl && !reg_wdata_i[CTRL_START];
	wire       w_timer   = (wcfg.tsel == TSEL_TIMER);
	wire       w_free    = (wcfg.tsel == TSEL_FREE);
	wire       cfg_ok    = (w_timer || w_free) && (wcfg.nsel != 3'h0);
	// Retrigger refused while a group or a drain is pending
	wire       launch    = start_req && !auto_start && (state == S_IDLE) && cfg_ok;
	wire       abort     = stop_req && auto_start;
	wire       is_timer  = (cfg.tsel == TSEL_TIMER);

	// Sequencing events
	wire       ovf       = timer_run && (tcnt == TMR_FULL);
	wire       done      = conv_rsp_i.done && conv_busy_o;
	wire       pair_end  = done && (!cfg.two || chan);
	wire       grp_end   = pair_end && ((pair_cnt + 1'b1) == n_target);
	wire       gap_tick  = (unit_cnt == 8'(GAP_UNIT - 1));
	wire       gap_over  = (gap_cnt == cfg.gap);
	wire       pair_busy = (state == S_CONV) || (state == S_GAP);

	always_comb
	begin
		next_state    = state;
		fire          = 1'b0;
		fire_chan     = 1'b0;
		gap_enter     = 1'b0;
		next_gap_chan = 1'b0;
		case (state)
			S_IDLE:
			begin
				if (launch && w_free)
				begin
					fire       = 1'b1;
					next_state = S_CONV;
				end
				else if (launch)
					next_state = S_WAIT;
			end
			S_WAIT:
			begin
				if (abort)
					next_state = S_IDLE;
				else if (ovf)
				begin
					fire       = 1'b1;
					next_state = S_CONV;
				end
			end
			S_CONV:
			begin
				if (done && (grp_end || abort))
					next_state = S_IDLE;
				else if (abort)
					next_state = S_DRAIN;
				else if (done && cfg.two && !chan)
				begin
					gap_enter     = 1'b1;
					next_gap_chan = 1'b1;
					next_state    = S_GAP;
				end
				else if (done && is_timer)
					next_state = S_WAIT;
				else if (done)
				begin
					gap_enter  = 1'b1;
					next_state = S_GAP;
				end
			end
			S_GAP:
			begin
				if (abort)
					next_state = S_IDLE;
				else if (gap_over)
				begin
					fire       = 1'b1;
					fire_chan  = gap_chan;
					next_state = S_CONV;
				end
			end
			S_DRAIN:
			begin
				if (done)
					next_state = S_IDLE;
			end
			default:
				next_state = S_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			state <= S_IDLE;
		else
			state <= next_state;
	end

	// Config only changes between groups
	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			cfg <= CFG_RST;
		else if (wr_ctrl && state == S_IDLE && !auto_start)
			cfg <= wcfg;
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			auto_start <= 1'b0;
		else if (launch)
			auto_start <= 1'b1;
		else if (abort || grp_end)
			auto_start <= 1'b0;
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			timer_run <= 1'b0;
		else if (launch && w_timer)
			timer_run <= 1'b1;
		else if (grp_end || (abort && (state != S_CONV || done)))
			timer_run <= 1'b0;
		else if ((state == S_DRAIN && done) || (wr_stat && reg_wdata_i[STAT_RUN]))
			timer_run <= 1'b0;
	end

	// Preload is only sampled at start and at overflow
	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			preload <= PRELOAD_RST;
		else if (wr_pre)
			preload <= reg_wdata_i[TMR_W-1:0];
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			tcnt <= PRELOAD_RST;
		else if (launch)
			tcnt <= preload;
		else if (ovf)
			tcnt <= preload;
		else if (timer_run)
			tcnt <= tcnt + 1'b1;
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			overrun <= 1'b0;
		else if (launch)
			overrun <= 1'b0;
		else if (ovf && pair_busy)
			overrun <= 1'b1;
	end

	// Completion set wins over a software clear in the same cycle
	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			adc_irq_flag_o <= 1'b0;
		else if (grp_end)
			adc_irq_flag_o <= 1'b1;
		else if (wr_stat && reg_wdata_i[STAT_IRQ])
			adc_irq_flag_o <= 1'b0;
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			conv_busy_o <= 1'b0;
		else if (fire)
			conv_busy_o <= 1'b1;
		else if (done)
			conv_busy_o <= 1'b0;
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			acc <= '0;
		else if (launch)
			acc <= '0;
		else if (done)
			acc <= acc + ACC_W'(conv_rsp_i.data);
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			pair_cnt <= '0;
			n_target <= '0;
		end
		else if (launch)
		begin
			pair_cnt <= '0;
			n_target <= n_of(wcfg.nsel);
		end
		else if (pair_end)
			pair_cnt <= pair_cnt + 1'b1;
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			chan       <= 1'b0;
			gap_chan   <= 1'b0;
			conv_req_o <= '0;
		end
		else
		begin
			conv_req_o <= '{start: fire, chan: fire_chan};
			if (fire)
				chan <= fire_chan;
			if (gap_enter)
				gap_chan <= next_gap_chan;
		end
	end

	// Gap timing in GAP_UNIT-cycle ticks trades resolution for a small counter
	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			unit_cnt <= '0;
			gap_cnt  <= '0;
		end
		else if (gap_enter)
		begin
			unit_cnt <= '0;
			gap_cnt  <= '0;
		end
		else if (state == S_GAP)
		begin
			unit_cnt <= gap_tick ? 8'h00 : unit_cnt + 1'b1;
			if (gap_tick && !gap_over)
				gap_cnt <= gap_cnt + 1'b1;
		end
	end

	// Read mux
	wire [31:0] stat_word = 32'({conv_busy_o, overrun, adc_irq_flag_o, timer_run, auto_start});
	wire [31:0] rd_word   = (reg_addr_i == OFS_CTRL)    ? 32'({auto_start, cfg}) :
	                        (reg_addr_i == OFS_STAT)    ? stat_word :
	                        (reg_addr_i == OFS_PRELOAD) ? 32'(preload) :
	                        (reg_addr_i == OFS_RESULT)  ? 32'(acc) :
	                        (reg_addr_i == OFS_COUNT)   ? 32'(tcnt) : 32'h0000_0000;

	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			reg_rdata_o <= 32'h0000_0000;
		else
			reg_rdata_o <= reg_rd_i ? rd_word : 32'h0000_0000;
	end

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!resetn_i);

	timer_start_a: assert property (launch && w_timer |=> timer_run && auto_start && !overrun)
		else $error("timer start did not arm timer");
	ovf_reload_a: assert property (ovf |=> tcnt == $past(preload))
		else $error("counter not reloaded after overflow");
	ovf_fire_a: assert property (state == S_WAIT && ovf && !abort |=> conv_req_o.start && !conv_req_o.chan)
		else $error("overflow did not start channel one");
	overrun_set_a: assert property (ovf && state == S_CONV |=> overrun && !conv_req_o.start)
		else $error("overflow during conversion not flagged");
	group_done_a: assert property (grp_end |=> !auto_start && !timer_run && adc_irq_flag_o)
		else $error("group end did not finish sequence");
	free_start_a: assert property (launch && w_free |=> conv_req_o.start && conv_busy_o)
		else $error("free mode did not convert at once");
	drain_hold_a: assert property (abort && state == S_CONV && !done |=> state == S_DRAIN ##1 $past(done) || state == S_DRAIN)
		else $error("busy abort did not drain");
	no_retrig_a: assert property (auto_start && start_req && !done |=> auto_start && $stable(pair_cnt))
		else $error("retrigger disturbed running group");
	gap_pair_a: assert property (state == S_CONV && done && cfg.two && !chan && !abort && !grp_end |=> state == S_GAP && !conv_busy_o)
		else $error("channel one not followed by gap");

	group_cov: cover property (grp_end ##1 adc_irq_flag_o);
	overrun_cov: cover property (ovf && pair_busy);
	drain_cov: cover property (state == S_DRAIN ##[1:50] state == S_IDLE);

endmodule : aas_sequencer

//--- testbench/aas_conv_model.sv
`timescale 1ns/1ps

module aas_conv_model
(
	input  wire logic                   clk_i,
	input  wire logic                   resetn_i,
	input  wire aas_pkg::aas_conv_req_s req_i,
	input  wire logic [7:0]             lat_i,
	input  wire logic [11:0]            dval_i,
	output aas_pkg::aas_conv_rsp_s      rsp_o,
	output logic [7:0]                  n_starts_o,
	output logic                        last_chan_o
);
	import aas_pkg::*;

	logic       busy;
	logic [7:0] cnt;

	// Data toggles outside done so a stale value never looks valid
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			rsp_o       <= '0;
			busy        <= 1'b0;
			cnt         <= 8'h00;
			n_starts_o  <= 8'h00;
			last_chan_o <= 1'b0;
		end
		else
		begin
			rsp_o.done <= 1'b0;
			rsp_o.data <= ~rsp_o.data;
			if (req_i.start)
			begin
				busy        <= 1'b1;
				cnt         <= lat_i;
				n_starts_o  <= n_starts_o + 8'h01;
				last_chan_o <= req_i.chan;
			end
			else if (busy && cnt == 8'h00)
			begin
				rsp_o.done <= 1'b1;
				rsp_o.data <= dval_i;
				busy       <= 1'b0;
			end
			else if (busy)
				cnt <= cnt - 8'h01;
		end
	end
endmodule : aas_conv_model

//--- testbench/tb_top.sv
`timescale 1ns/1ps

module tb_top;
	import aas_pkg::*;
	logic          clk = 1'b0;
	logic          resetn = 1'b0;
	logic [7:0]    addr = 8'h00;
	logic [31:0]   wdata = 32'h0;
	logic          wr = 1'b0;
	logic          rd = 1'b0;
	logic [31:0]   rdata;
	aas_conv_req_s req;
	aas_conv_rsp_s rsp;
	logic          busy;
	logic          irq;
	logic [7:0]    lat = 8'h03;
	logic [11:0]   dval = 12'h123;
	logic [7:0]    n_starts;
	logic          last_chan;
	logic [31:0]   rv;
	logic [31:0]   rv2;
	logic [7:0]    n0;
	int            n_errors = 0;
	int            compares = 0;
	int            cycles = 0;

	always #2.5 clk = ~clk;

	aas_sequencer #(.GAP_UNIT(2)) i_dut (
		.ref_clk_i      (clk),
		.resetn_i       (resetn),
		.reg_addr_i     (addr),
		.reg_wdata_i    (wdata),
		.reg_wr_i       (wr),
		.reg_rd_i       (rd),
		.reg_rdata_o    (rdata),
		.conv_req_o     (req),
		.conv_rsp_i     (rsp),
		.conv_busy_o    (busy),
		.adc_irq_flag_o (irq)
	);

	aas_conv_model i_core (
		.clk_i       (clk),
		.resetn_i    (resetn),
		.req_i       (req),
		.lat_i       (lat),
		.dval_i      (dval),
		.rsp_o       (rsp),
		.n_starts_o  (n_starts),
		.last_chan_o (last_chan)
	);

	task print_verdict;
		if (n_errors == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : print_verdict

	task check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			n_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	task wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg

	task rd_reg(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask : rd_reg

	// Bounded poll, then check that the flag is set; callers clear it afterwards
	task wait_irq;
		int k;
		k = 0;
		while (irq !== 1'b1 && k < 3000)
		begin
			@(posedge clk);
			k++;
		end
		check({31'h0, irq}, 32'h1);
	endtask : wait_irq

	// Sixteen-cycle period outlasts one conversion, so no overrun
	task t_timer_single;
		n0 = n_starts;
		wr_reg(OFS_PRELOAD, 32'h0000FFF0);
		wr_reg(OFS_CTRL, 32'h40A);
		rd_reg(OFS_STAT, rv);
		check({30'h0, rv[1:0]}, 32'h3);
		wait_irq();
		check({24'h0, n_starts - n0}, 32'h2);
		rd_reg(OFS_STAT, rv);
		check({27'h0, rv[4:0]}, 32'h04);
		rd_reg(OFS_RESULT, rv);
		check(rv, {19'h0, dval, 1'b0});
		rd_reg(8'h20, rv);
		check(rv, 32'h0);
		wr_reg(OFS_STAT, 32'h4);
	endtask : t_timer_single

	task t_free_single;
		n0 = n_starts;
		wr_reg(OFS_CTRL, 32'h44B);
		wr_reg(OFS_CTRL, 32'h41B);
		wait_irq();
		check({24'h0, n_starts - n0}, 32'h2);
		rd_reg(OFS_STAT, rv);
		check({27'h0, rv[4:0]}, 32'h04);
		rd_reg(OFS_RESULT, rv);
		check(rv, {19'h0, dval, 1'b0});
		wr_reg(OFS_STAT, 32'h4);
	endtask : t_free_single

	task t_free_two;
		n0 = n_starts;
		wr_reg(OFS_CTRL, 32'h427);
		wait_irq();
		check({24'h0, n_starts - n0}, 32'h2);
		check({31'h0, last_chan}, 32'h1);
		wr_reg(OFS_STAT, 32'h4);
	endtask : t_free_two

	// Timer pairs against a two-cycle period: every pair overruns
	task t_timer_two;
		n0 = n_starts;
		wr_reg(OFS_PRELOAD, 32'h0000FFFE);
		wr_reg(OFS_CTRL, 32'h46A);
		wait_irq();
		check({24'h0, n_starts - n0}, 32'h4);
		check({31'h0, last_chan}, 32'h1);
		rd_reg(OFS_STAT, rv);
		check({27'h0, rv[4:0]}, 32'h0C);
		rd_reg(OFS_RESULT, rv);
		check(rv, {18'h0, dval, 2'b0});
		wr_reg(OFS_STAT, 32'h4);
	endtask : t_timer_two

	// Slow core against a two-cycle timer period
	task t_overrun_abort;
		lat <= 8'd10;
		n0 = n_starts;
		wr_reg(OFS_PRELOAD, 32'h0000FFFE);
		wr_reg(OFS_CTRL, 32'h406);
		wait_irq();
		rd_reg(OFS_STAT, rv);
		check({27'h0, rv[4:0]}, 32'h0C);
		check({24'h0, n_starts - n0}, 32'h1);
		wr_reg(OFS_STAT, 32'h4);
		wr_reg(OFS_PRELOAD, 32'h0);
		wr_reg(OFS_CTRL, 32'h406);
		rd_reg(OFS_STAT, rv);
		check({27'h0, rv[4:0]}, 32'h03);
		wr_reg(OFS_CTRL, 32'h006);
		rd_reg(OFS_STAT, rv);
		check({27'h0, rv[4:0]}, 32'h00);
		rd_reg(OFS_COUNT, rv);
		rd_reg(OFS_COUNT, rv2);
		check(rv2, rv);
	endtask : t_overrun_abort

	task t_abort_busy;
		int k;
		lat <= 8'd20;
		n0 = n_starts;
		k = 0;
		wr_reg(OFS_PRELOAD, 32'h0000FFFE);
		wr_reg(OFS_CTRL, 32'h40A);
		while (n_starts == n0 && k < 50)
		begin
			@(posedge clk);
			k++;
		end
		wr_reg(OFS_CTRL, 32'h00A);
		rd_reg(OFS_STAT, rv);
		check({31'h0, rv[4]}, 32'h1);
		repeat (30) @(posedge clk);
		rd_reg(OFS_STAT, rv);
		check({27'h0, rv[4:0]}, 32'h08);
		check({24'h0, n_starts - n0}, 32'h1);
		lat <= 8'h03;
	endtask : t_abort_busy

	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			n_errors++;
			print_verdict();
		end
	end

	initial
	begin
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		t_timer_single();
		t_free_single();
		t_free_two();
		t_timer_two();
		t_overrun_abort();
		t_abort_busy();
		print_verdict();
	end
endmodule : tb_top
